// file: rtl/dio_regs.svh
// Purpose: register indices, field positions and reset values of the dual i/o port
// Assumes: 32-bit classic wishbone, byte address = 4 * index
// Notes: definitions only
`ifndef DIO_REGS_SVH
`define DIO_REGS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define DIO_IDX_LATCH_A 8'hC0
`define DIO_IDX_LATCH_B 8'hC1
`define DIO_IDX_DIR_A 8'hC4
`define DIO_IDX_DIR_B 8'hC5
`define DIO_IDX_OPT_A 8'hCC
`define DIO_IDX_OPT_B 8'hCD
`define DIO_IDX_IRQ_OPT 8'hD0
`define DIO_IDX_TRIG 8'hD1
`define DIO_IDX_STAT 8'hD2
`define DIO_IDX_MASK 8'hD3

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define DIO_GEN_BIT 0
`define DIO_TRIG_W 2
`define DIO_RST_PORT 8'h00
`define DIO_RST_TRIG 8'h00
`define DIO_RST_PIN 8'hFF
`define DIO_ANA_CAP_A 8'hFF
`define DIO_ANA_CAP_B 8'hFF
`define DIO_ADR_HI_ZERO 2'h0

`endif

// file: rtl/dio_pkg.sv
// Purpose: types shared by the dual i/o port
// Assumes: nothing
// Notes: constants live in dio_regs.svh
package dio_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DIO_TRIG_FALL,
    DIO_TRIG_RISE,
    DIO_TRIG_LOW
  } dio_trig_t;

  typedef struct packed {
    logic [7:0] pad_out;
    logic [7:0] pad_oe_b;
    logic [7:0] pull_up;
    logic [7:0] analog_sel;
  } dio_pad_t;

endpackage : dio_pkg

// file: rtl/dio_sync.sv
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: async_i from a pin
// Notes: output changes once second and third stage agree
`timescale 1ns/1ns
`default_nettype none

module dio_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;

  // reset to high: pins come up pulled up, so no false falling edge
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_r <= '1;
    end else begin
      out_r <= (s2_r & s3_r) | (out_r & (s2_r ^ s3_r));
    end
  end

  assign sync_o = out_r;

endmodule : dio_sync
`default_nettype wire

// file: rtl/dio_port.sv
// Purpose: two 8-bit general purpose i/o ports behind classic wishbone
// Assumes: 10 MHz clock_i, asynchronous active-low rst_b_i
// Notes: pads are split into value, enable (low drives), pull-up and analog select
`timescale 1ns/1ns
`default_nettype none
`include "dio_regs.svh"

// Notes on behaviour
// - ports a and b each have a data latch, direction and option register, bit x for pin x.
// - all port registers clear to zero at reset, giving input with pull-up and no interrupt.
// - reading a data register gives the latch for output pins, the pin level for digital inputs and 0 for analog pins.
// - writing a data register always updates the latch, changing an input pin's sub-mode.
// - direction bits are read/write, 0 meaning input and 1 meaning output.
// - in output mode option 0 is open-drain with the high side off and 1 is push-pull.
// - for input pins the option bit also selects the input sub-mode.
// - a pin raises an interrupt only in input-with-interrupt mode with the global gate set.
// - wait leaves port state alone and a qualified pin interrupt wakes the device.
// - stop leaves port state alone and a qualified pin interrupt wakes the device.
// - an analog-capable input pin with option 1 and data 1 goes to the converter.
// - input modes by option and data: 00 pull-up, 01 plain, 10 pull-up with irq, 11 analog.
// - each port selects falling edge, rising edge or low level as its trigger.
module dio_port (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pin_a_i,
  input wire logic [7:0] pin_b_i,
  output dio_pkg::dio_pad_t pad_a_o,
  output dio_pkg::dio_pad_t pad_b_o,
  output logic [1:0] ext_irq_o,
  output logic irq_o,
  output logic wake_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] latch_r [2];
  logic [7:0] dir_r [2];
  logic [7:0] opt_r [2];
  logic [7:0] irq_opt_r;
  logic [7:0] trig_r;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] mask_r;
  logic ack_r;
  logic [31:0] rdat_r;

  logic [7:0] pin_raw [2];
  logic [7:0] pin_s [2];
  logic [7:0] prev_r [2];
  logic [7:0] din [2];
  logic [1:0] port_evt;
  dio_pkg::dio_pad_t pad [2];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr_fire;
  logic [7:0] idx;
  logic mapped;
  logic [7:0] rd_val;
  logic [7:0] wdat;

  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[9:2];
  // write lands on the edge where the master sees ack
  assign wr_fire = req & wb_we_i & ack_r & wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    if (wb_adr_i[11:10] != `DIO_ADR_HI_ZERO) begin
      mapped = 1'b0;
    end else if (idx == `DIO_IDX_LATCH_A) begin
      rd_val = din[0];
    end else if (idx == `DIO_IDX_LATCH_B) begin
      rd_val = din[1];
    end else if (idx == `DIO_IDX_DIR_A) begin
      rd_val = dir_r[0];
    end else if (idx == `DIO_IDX_DIR_B) begin
      rd_val = dir_r[1];
    end else if (idx == `DIO_IDX_OPT_A) begin
      rd_val = opt_r[0];
    end else if (idx == `DIO_IDX_OPT_B) begin
      rd_val = opt_r[1];
    end else if (idx == `DIO_IDX_IRQ_OPT) begin
      rd_val = irq_opt_r;
    end else if (idx == `DIO_IDX_TRIG) begin
      rd_val = trig_r;
    end else if (idx == `DIO_IDX_STAT) begin
      rd_val = {6'h00, stat_r};
    end else if (idx == `DIO_IDX_MASK) begin
      rd_val = {6'h00, mask_r};
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // unmapped reads answer zero; data captured as ack is raised
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (req & ~ack_r) begin
      rdat_r <= mapped ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------------------------------
  // port registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_r[0] <= `DIO_RST_PORT;
      latch_r[1] <= `DIO_RST_PORT;
    end else if (wr_fire && idx == `DIO_IDX_LATCH_A) begin
      latch_r[0] <= wdat;
    end else if (wr_fire && idx == `DIO_IDX_LATCH_B) begin
      latch_r[1] <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_r[0] <= `DIO_RST_PORT;
      dir_r[1] <= `DIO_RST_PORT;
    end else if (wr_fire && idx == `DIO_IDX_DIR_A) begin
      dir_r[0] <= wdat;
    end else if (wr_fire && idx == `DIO_IDX_DIR_B) begin
      dir_r[1] <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opt_r[0] <= `DIO_RST_PORT;
      opt_r[1] <= `DIO_RST_PORT;
    end else if (wr_fire && idx == `DIO_IDX_OPT_A) begin
      opt_r[0] <= wdat;
    end else if (wr_fire && idx == `DIO_IDX_OPT_B) begin
      opt_r[1] <= wdat;
    end
  end

  // ----------------------------------------------------------------
  // interrupt control
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_opt_r <= `DIO_RST_PORT;
    end else if (wr_fire && idx == `DIO_IDX_IRQ_OPT) begin
      irq_opt_r <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_r <= `DIO_RST_TRIG;
    end else if (wr_fire && idx == `DIO_IDX_TRIG) begin
      trig_r <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_r <= 2'h0;
    end else if (wr_fire && idx == `DIO_IDX_MASK) begin
      mask_r <= wdat[1:0];
    end
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  // new events win over a write-one clear in the same cycle
  always_comb begin
    stat_nxt = stat_r;
    if (wr_fire && idx == `DIO_IDX_STAT) begin
      stat_nxt = stat_r & ~wdat[1:0];
    end
    stat_nxt = stat_nxt | port_evt;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_r <= 2'h0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------
  assign irq_o = |(stat_r & mask_r);
  // wake is combinational from flops: usable while the core sleeps
  assign wake_o = irq_o;

  // ----------------------------------------------------------------
  // per-port pin logic
  // ----------------------------------------------------------------
  assign pin_raw[0] = pin_a_i;
  assign pin_raw[1] = pin_b_i;

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0] in_mode;
    logic [7:0] qual;
    logic [7:0] ana;
    logic [7:0] cap;
    logic [7:0] hit;
    logic [7:0] drive;

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    assign cap = (p == 0) ? `DIO_ANA_CAP_A : `DIO_ANA_CAP_B;
    assign in_mode = ~dir_r[p];
    // option 1, data 0 on an input: interrupt mode
    assign qual = in_mode & opt_r[p] & ~latch_r[p];
    assign ana = in_mode & opt_r[p] & latch_r[p] & cap;

    // ----------------------------------------------------------------
    // synchroniser
    // ----------------------------------------------------------------
    dio_sync #(
      .WIDTH(8)
    ) u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .async_i(pin_raw[p]),
      .sync_o(pin_s[p])
    );

    // ----------------------------------------------------------------
    // edge history
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        prev_r[p] <= `DIO_RST_PIN;
      end else begin
        prev_r[p] <= pin_s[p];
      end
    end

    // an analog pin has its digital path cut, so it reads low
    assign din[p] = (dir_r[p] & latch_r[p]) | (in_mode & pin_s[p] & ~ana);

    // ----------------------------------------------------------------
    // event detect
    // ----------------------------------------------------------------
    // reserved trigger code 11 behaves as falling edge
    always_comb begin
      case (dio_pkg::dio_trig_t'(trig_r[p*`DIO_TRIG_W +: `DIO_TRIG_W]))
        dio_pkg::DIO_TRIG_RISE: hit = pin_s[p] & ~prev_r[p];
        dio_pkg::DIO_TRIG_LOW: hit = ~pin_s[p];
        default: hit = prev_r[p] & ~pin_s[p];
      endcase
    end

    assign port_evt[p] = irq_opt_r[`DIO_GEN_BIT] & |(qual & hit);
    assign ext_irq_o[p] = stat_r[p];

    // ----------------------------------------------------------------
    // pad control
    // ----------------------------------------------------------------
    // open-drain drives only a low; push-pull drives both levels
    assign drive = dir_r[p] & (opt_r[p] | ~latch_r[p]);
    assign pad[p].pad_out = latch_r[p] & dir_r[p];
    assign pad[p].pad_oe_b = ~drive;
    assign pad[p].pull_up = in_mode & ~latch_r[p];
    assign pad[p].analog_sel = ana;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pad_a_o = pad[0];
  assign pad_b_o = pad[1];

endmodule : dio_port
`default_nettype wire

// file: dv/dio_port_properties.sv
// Purpose: bus, pad and interrupt relations of the dual i/o port
// Assumes: sees the ports of dio_port only
// Notes: bound to dio_port at the foot of this file
`timescale 1ns/1ns
`default_nettype none

module dio_port_properties (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire dio_pkg::dio_pad_t pad_a_o,
  input wire dio_pkg::dio_pad_t pad_b_o,
  input wire logic [1:0] ext_irq_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  a_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_hi_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_wake_is_irq: assert property (wake_o == irq_o)
    else $error("wake differs from interrupt");
  a_irq_needs_stat: assert property (irq_o |-> ext_irq_o != 2'h0)
    else $error("interrupt without status");
  // status only falls through a bus write
  a_stat_sticky: assert property ((($past(ext_irq_o) & ~ext_irq_o) != 2'h0)
    |-> $past(wb_ack_o && wb_we_i))
    else $error("status fell without write");
  a_pull_not_drv: assert property (((pad_a_o.pull_up & ~pad_a_o.pad_oe_b)
    | (pad_b_o.pull_up & ~pad_b_o.pad_oe_b)) == 8'h00)
    else $error("pull-up on driven pin");
  a_analog_alone: assert property ((pad_a_o.analog_sel
    & (pad_a_o.pull_up | ~pad_a_o.pad_oe_b)) == 8'h00)
    else $error("analog pin driven or pulled");
  c_irq: cover property (irq_o);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_analog: cover property (pad_a_o.analog_sel != 8'h00);
endmodule : dio_port_properties

bind dio_port dio_port_properties u_prop (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pad_a_o(pad_a_o), .pad_b_o(pad_b_o), .ext_irq_o(ext_irq_o),
  .irq_o(irq_o), .wake_o(wake_o));

`default_nettype wire

// file: dv/dio_pin_model.sv
// Purpose: external circuitry on one 8-pin port
// Assumes: pads from dio_port, bench drive per pin
// Notes: an undriven pin without pull-up wanders each cycle
`timescale 1ns/1ns
`default_nettype none

module dio_pin_model (
  input wire logic clock_i,
  input wire dio_pkg::dio_pad_t pad_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_o
);
  logic flip_r = 1'b0;
  always @(posedge clock_i) begin
    flip_r <= ~flip_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_i.pad_oe_b[i]) begin
        pin_o[i] = pad_i.pad_out[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else if (pad_i.pull_up[i]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = flip_r;
      end
    end
  end
endmodule : dio_pin_model

`default_nettype wire

// file: dv/tb_dual_8bit_io_port.sv
// Purpose: self-checking bench of the dual i/o port
// Assumes: classic wishbone, 10 MHz clock
// Notes: pins come from dio_pin_model
`timescale 1ns/1ns
`default_nettype none
`include "dio_regs.svh"

module tb_dual_8bit_io_port;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic ack;
  logic irq_o;
  logic wake_o;
  logic [1:0] ext_irq_o;
  logic [7:0] pin_a;
  logic [7:0] pin_b;
  logic [7:0] en_a = 8'h00;
  logic [7:0] val_a = 8'h00;
  logic [7:0] en_b = 8'h00;
  logic [7:0] val_b = 8'h00;
  dio_pkg::dio_pad_t pad_a;
  dio_pkg::dio_pad_t pad_b;
  int bad_count = 0;
  int tests_run = 0;
  int cycle_count = 0;
  always #50 clock_i = ~clock_i;
  dio_port u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(ack), .pin_a_i(pin_a), .pin_b_i(pin_b), .pad_a_o(pad_a), .pad_b_o(pad_b),
    .ext_irq_o(ext_irq_o), .irq_o(irq_o), .wake_o(wake_o));
  dio_pin_model u_pin_a (.clock_i(clock_i), .pad_i(pad_a), .ext_en_i(en_a),
    .ext_val_i(val_a), .pin_o(pin_a));
  dio_pin_model u_pin_b (.clock_i(clock_i), .pad_i(pad_b), .ext_en_i(en_b),
    .ext_val_i(val_b), .pin_o(pin_b));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    dat <= {24'h0, d};
    @(posedge clock_i);
    while (ack !== 1'b1) @(posedge clock_i);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask : wr
  task automatic rg(input logic [9:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rg
  task automatic t_reset();
    chk(pad_a, 32'h00FFFF00);
    rg(`DIO_IDX_DIR_A, 32'h0);
    rg(`DIO_IDX_OPT_B, 32'h0);
    rg(`DIO_IDX_LATCH_B, 32'hFF);
    wr(10'h3C0, 8'h55);
    rg(10'h3C0, 32'h0);
    rg(`DIO_IDX_LATCH_A, 32'hFF);
  endtask : t_reset
  task automatic t_output();
    wr(`DIO_IDX_DIR_A, 8'hFF);
    rg(`DIO_IDX_DIR_A, 32'hFF);
    wr(`DIO_IDX_OPT_A, 8'h0F);
    wr(`DIO_IDX_LATCH_A, 8'h5A);
    @(negedge clock_i);
    chk(pad_a.pad_oe_b, 32'h50);
    chk(pad_a.pad_out & ~pad_a.pad_oe_b, 32'h0A);
    rg(`DIO_IDX_LATCH_A, 32'h5A);
    wr(`DIO_IDX_DIR_A, 8'h00);
  endtask : t_output
  task automatic t_input();
    wr(`DIO_IDX_OPT_A, 8'h00);
    en_a <= 8'hFF;
    val_a <= 8'h96;
    wr(`DIO_IDX_LATCH_A, 8'hFF);
    @(negedge clock_i);
    chk(pad_a.pull_up, 32'h00);
    rg(`DIO_IDX_LATCH_A, 32'h96);
    wr(`DIO_IDX_LATCH_A, 8'h00);
    @(negedge clock_i);
    chk(pad_a.pull_up, 32'hFF);
    wr(`DIO_IDX_OPT_A, 8'hFF);
    wr(`DIO_IDX_LATCH_A, 8'hF0);
    @(negedge clock_i);
    chk({pad_a.analog_sel, pad_a.pull_up}, 32'hF00F);
    rg(`DIO_IDX_LATCH_A, 32'h06);
  endtask : t_input
  task automatic t_irq();
    wr(`DIO_IDX_OPT_A, 8'h01);
    wr(`DIO_IDX_LATCH_A, 8'h00);
    wr(`DIO_IDX_IRQ_OPT, 8'h01);
    wr(`DIO_IDX_MASK, 8'h01);
    for (int c = 0; c < 3; c++) begin
      wr(`DIO_IDX_TRIG, 8'(c));
      val_a <= (c == 1) ? 8'h00 : 8'hFF;
      repeat (8) @(posedge clock_i);
      wr(`DIO_IDX_STAT, 8'h03);
      rg(`DIO_IDX_STAT, 32'h0);
      val_a <= ~val_a;
      repeat (8) @(posedge clock_i);
      chk({irq_o, wake_o, ext_irq_o}, 32'hD);
    end
    wr(`DIO_IDX_STAT, 8'h01);
    rg(`DIO_IDX_STAT, 32'h1);
    wr(`DIO_IDX_MASK, 8'h00);
    @(negedge clock_i);
    chk({irq_o, wake_o, ext_irq_o}, 32'h1);
    wr(`DIO_IDX_IRQ_OPT, 8'h00);
    wr(`DIO_IDX_TRIG, 8'h00);
    val_a <= 8'hFF;
    repeat (8) @(posedge clock_i);
    wr(`DIO_IDX_STAT, 8'h03);
    val_a <= 8'h00;
    repeat (8) @(posedge clock_i);
    chk(ext_irq_o, 32'h0);
  endtask : t_irq
  task automatic t_port_b();
    wr(`DIO_IDX_DIR_B, 8'hF0);
    wr(`DIO_IDX_OPT_B, 8'h31);
    wr(`DIO_IDX_LATCH_B, 8'hA0);
    @(negedge clock_i);
    chk(pad_b, 32'hA08F0F00);
    rg(`DIO_IDX_LATCH_B, 32'hAF);
    wr(`DIO_IDX_TRIG, 8'h0C);
    wr(`DIO_IDX_IRQ_OPT, 8'h01);
    wr(`DIO_IDX_MASK, 8'h02);
    en_b <= 8'h01;
    val_b <= 8'h00;
    repeat (8) @(posedge clock_i);
    chk({irq_o, wake_o, ext_irq_o}, 32'hE);
    rg(`DIO_IDX_STAT, 32'h2);
    wr(`DIO_IDX_STAT, 8'h02);
    val_b <= 8'h01;
    repeat (8) @(posedge clock_i);
    chk(ext_irq_o, 32'h0);
  endtask : t_port_b
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_output();
    t_input();
    t_irq();
    t_port_b();
    test_done();
  end
endmodule : tb_dual_8bit_io_port

`default_nettype wire
